/* File: rtl/ahpcr_defines.vh */
`ifndef AHPCR_DEFINES_VH
`define AHPCR_DEFINES_VH
// register addresses on page 1
`define AHPCR_ADDR_NUM1_LO 7'h4a
`define AHPCR_ADDR_DEN1_HI 7'h4b
`define AHPCR_ADDR_DEN1_LO 7'h4c
`define AHPCR_ADDR_RSVD_FIRST 7'h4d
`define AHPCR_ADDR_RSVD_LAST 7'h7f
// reset values
`define AHPCR_RST_NUM1_LO 8'h2d
`define AHPCR_RST_DEN1_HI 8'h00
`define AHPCR_RST_DEN1_LO 8'h7e
`define AHPCR_RST_NUM1_HI 8'h00
`define AHPCR_RST_RSVD 8'h00
`endif

/* File: rtl/ahpcr_byte_reg.v */
`default_nettype none
module ahpcr_byte_reg #(
	parameter [7:0] RESET_VAL = 8'h00
) (
	// clock and reset
	input wire clk,
	input wire rstn,
	// write side
	input wire wr_en,
	input wire [7:0] wr_data,
	// value
	output reg [7:0] q
);
	always @(posedge clk) begin
		if (!rstn)
			q <= RESET_VAL;
		else if (wr_en)
			q <= wr_data;
	end
endmodule
`default_nettype wire

/* File: rtl/ahpcr_regs.v */
// Behaviour
// R1 - coefficient is 16-bit two's complement from high and low bytes
// R2 - numerator-one low byte at address 74 resets to 0x2d
// R3 - denominator-one low byte at address 76 resets to 0x7e
// R4 - denominator-one high byte at address 75 is full read/write byte
// R5 - addresses 77 to 127 read zero; host never writes them
// R6 - host reaches all features through registers over strapped bus
// R7 - host should apply a hardware reset after power-up
// R8 - reset held low until all supplies are stable
// R9 - all timing comes from the master clock, set up before power-up
// R10 - stages come up powered down; host writes registers to enable
// R11 - denominator-one high byte resets to a fixed default of 0x00
`include "ahpcr_defines.vh"
`default_nettype none
module ahpcr_regs (
	// master clock and reset
	input wire clk,
	input wire rstn,

	// decoded page-1 register access from the control port
	input wire wr_en,
	input wire rd_en,
	input wire [6:0] addr,
	input wire [7:0] wr_data,
	output wire [7:0] rd_data,
	output wire rd_valid,

	// numerator-one high byte held by the neighbouring block
	input wire [7:0] num1_hi,

	// coefficients to the filter
	output wire signed [15:0] hpf_numerator_one,
	output wire signed [15:0] hpf_denominator_one,

	// stage enable, low out of reset
	output wire coeff_written
);

	////////////////////////////////////////////////////////////////
	// one-hot selects of the storage bytes
	localparam [2:0] SEL_NONE = 3'b000;
	localparam [2:0] SEL_NUM1_LO = 3'b001;
	localparam [2:0] SEL_DEN1_HI = 3'b010;
	localparam [2:0] SEL_DEN1_LO = 3'b100;

	////////////////////////////////////////////////////////////////
	// decode helpers; reg_select is shared by write and read paths, the others serve reads only

	// storage byte behind an address, none for unmapped ones
	function [2:0] reg_select;
		input [6:0] a;
		case (a)
		`AHPCR_ADDR_NUM1_LO: reg_select = SEL_NUM1_LO;
		`AHPCR_ADDR_DEN1_HI: reg_select = SEL_DEN1_HI;
		`AHPCR_ADDR_DEN1_LO: reg_select = SEL_DEN1_LO;
		default: reg_select = SEL_NONE;
		endcase
	endfunction

	// reserved tail of the page
	function in_reserved;
		input [6:0] a;
		in_reserved = (a >= `AHPCR_ADDR_RSVD_FIRST);
	endfunction

	// read data for a select; unmapped bytes read zero
	function [7:0] read_mux;
		input [2:0] sel;
		input [7:0] b_num1_lo;
		input [7:0] b_den1_hi;
		input [7:0] b_den1_lo;
		case (sel)
		SEL_NUM1_LO: read_mux = b_num1_lo;
		SEL_DEN1_HI: read_mux = b_den1_hi;
		SEL_DEN1_LO: read_mux = b_den1_lo;
		default: read_mux = `AHPCR_RST_RSVD;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////
	// storage and control state
	wire [7:0] num1_lo;
	wire [7:0] den1_hi;
	wire [7:0] den1_lo;

	wire [2:0] wr_sel;
	wire [2:0] rd_sel;
	wire wr_num1_lo;
	wire wr_den1_hi;
	wire wr_den1_lo;
	wire wr_any;

	reg [7:0] rd_data_r;
	reg [7:0] rd_data_nxt;
	reg rd_valid_r;
	reg rd_valid_nxt;
	reg coeff_written_r;
	reg coeff_written_nxt;

	////////////////////////////////////////////////////////////////
	// writes; reserved range has no storage so writes are dropped
	assign wr_sel = wr_en ? reg_select(addr) : SEL_NONE; // [R5]
	assign rd_sel = reg_select(addr);

	assign wr_num1_lo = wr_sel[0];
	assign wr_den1_hi = wr_sel[1];
	assign wr_den1_lo = wr_sel[2];
	assign wr_any = |wr_sel;

	ahpcr_byte_reg #(.RESET_VAL(`AHPCR_RST_NUM1_LO)) u_num1_lo ( // [R2]
		.clk(clk),
		.rstn(rstn), // [R7]
		.wr_en(wr_num1_lo),
		.wr_data(wr_data),
		.q(num1_lo)
	);
	ahpcr_byte_reg #(.RESET_VAL(`AHPCR_RST_DEN1_HI)) u_den1_hi ( // [R4] [R11]
		.clk(clk),
		.rstn(rstn),
		.wr_en(wr_den1_hi),
		.wr_data(wr_data),
		.q(den1_hi)
	);
	ahpcr_byte_reg #(.RESET_VAL(`AHPCR_RST_DEN1_LO)) u_den1_lo ( // [R3]
		.clk(clk),
		.rstn(rstn),
		.wr_en(wr_den1_lo),
		.wr_data(wr_data),
		.q(den1_lo)
	);

	////////////////////////////////////////////////////////////////
	// coefficient assembly
	assign hpf_numerator_one = {num1_hi, num1_lo}; // [R1]
	assign hpf_denominator_one = {den1_hi, den1_lo}; // [R1]

	////////////////////////////////////////////////////////////////
	// reads, one cycle latency; data holds until the next read
	always @* begin
		rd_valid_nxt = rd_en;
		rd_data_nxt = rd_data_r;
		if (rd_en) begin
			if (in_reserved(addr)) begin
				rd_data_nxt = `AHPCR_RST_RSVD; // [R5]
			end else begin
				// [R4]
				rd_data_nxt = read_mux(rd_sel, num1_lo, den1_hi, den1_lo);
			end
		end
	end

	always @(posedge clk) begin // [R9]
		if (!rstn) begin
			rd_data_r <= `AHPCR_RST_RSVD;
			rd_valid_r <= 1'b0;
		end else begin
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
		end
	end

	assign rd_data = rd_data_r;
	assign rd_valid = rd_valid_r;

	////////////////////////////////////////////////////////////////
	// stage stays off until the host programs a coefficient
	always @* begin
		coeff_written_nxt = coeff_written_r;
		if (wr_any) begin
			coeff_written_nxt = 1'b1; // [R10]
		end
	end

	always @(posedge clk) begin
		if (!rstn) begin
			coeff_written_r <= 1'b0; // [R10]
		end else begin
			coeff_written_r <= coeff_written_nxt;
		end
	end

	assign coeff_written = coeff_written_r;

endmodule
`default_nettype wire

/* File: testbench/ahpcr_props.sv */
`default_nettype none
module ahpcr_props(input wire clk,rstn,wr_en,rd_en,rd_valid,
input wire [6:0] addr,input wire [7:0] wr_data,rd_data,num1_hi,
input wire signed [15:0] hpf_numerator_one,hpf_denominator_one,
input wire coeff_written);
	timeunit 1ns;
	timeprecision 100ps;
	wire [15:0] n=hpf_numerator_one,d=hpf_denominator_one;
	default clocking @(posedge clk);endclocking
	default disable iff(!rstn);
	rd_pulse_a:assert property(rd_valid==$past(rd_en))
		else $error("rv");
	den_hi_a:assert property(wr_en&&addr==7'h4b
		|=>d[15:8]==$past(wr_data)) else $error("dh");
	den_lo_a:assert property(wr_en&&addr==7'h4c
		|=>d[7:0]==$past(wr_data)) else $error("dl");
	num_lo_a:assert property(wr_en&&addr==7'h4a
		|=>n[7:0]==$past(wr_data)) else $error("nl");
	num_hi_a:assert property(n[15:8]==num1_hi)
		else $error("nh");
	rst_val_a:assert property($rose(rstn)
		|->n[7:0]==8'h2d&&d==16'h007e) else $error("rst");
	rsvd_rd_a:assert property(rd_en&&addr>7'h4c
		|=>rd_data==8'h00) else $error("rz");
	rsvd_wr_a:assert property(wr_en&&addr>7'h4c
		|=>$stable(d)&&$stable(n)) else $error("rw");
	stage_off_a:assert property($rose(rstn)
		|->!coeff_written) else $error("so");
	cover property(wr_en&&addr==7'h4c);
	cover property(rd_en&&addr>7'h4c);
	cover property($rose(rd_valid));
endmodule
bind ahpcr_regs ahpcr_props p(.*);
`default_nettype wire

/* File: testbench/ahpcr_host.sv */
`default_nettype none
module ahpcr_host(input wire logic clk,output logic wr_en,rd_en,
output logic [6:0] addr,output logic [7:0] wr_data);
	timeunit 1ns;
	timeprecision 100ps;
	initial {wr_en,rd_en,addr,wr_data}=0;
	task xfer(logic w,logic [6:0] a,logic [7:0] v);
		@(negedge clk);
		{wr_en,rd_en,addr,wr_data}={w,!w,a,v};
		@(negedge clk);
		{wr_en,rd_en,addr,wr_data}={2'b0,~a,~v};
	endtask
endmodule
`default_nettype wire

/* File: testbench/ahpcr_regs_tb_top.sv */
`default_nettype none
module ahpcr_regs_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk=0,rstn=0;
	logic [7:0] num1_hi=8'hf3;
	wire wr_en,rd_en,rd_valid,coeff_written;
	wire [6:0] addr;
	wire [7:0] wr_data,rd_data;
	wire [15:0] n,d;
	int error_cnt=0,checked=0;
	always #12.5 clk=~clk;
	ahpcr_host h(.*);
	ahpcr_regs DUT(.*,.hpf_numerator_one(n),.hpf_denominator_one(d));
	task c(string s,logic [15:0] e,g);
		checked++;
		if(g!==e)begin
			error_cnt++;
			$display("BAD %s exp %h got %h",s,e,g);
		end
	endtask
	task rd(logic [6:0] a,logic [7:0] e);
		h.xfer(0,a,0);
		c("rd",{8'h01,e},{7'h0,rd_valid,rd_data});
	endtask
	task tally_and_finish;
		$display("checked %0d error_cnt %0d",checked,error_cnt);
		if(error_cnt==0&&checked>0)$display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		#5us;
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		repeat(10)@(negedge clk);
		rstn=1;
		c("n",16'hf32d,n);
		c("d",16'h007e,d);
		rd(7'h4b,0);
		h.xfer(1,7'h4b,8'h80);
		h.xfer(1,7'h4c,0);
		c("d",16'h8000,d);
		c("en",1,coeff_written);
		h.xfer(1,7'h60,8'h55);
		rd(7'h60,0);
		rd(7'h7f,0);
		rd(7'h4b,8'h80);
		h.xfer(1,7'h4a,8'h81);
		c("n",16'hf381,n);
		rd(7'h4c,0);
		rd(7'h4a,8'h81);
		@(negedge clk);
		c("hold",16'h0081,{7'h0,rd_valid,rd_data});
		$display("test rw done");
		rstn=0;
		repeat(2)@(negedge clk);
		rstn=1;
		c("n",16'hf32d,n);
		c("d",16'h007e,d);
		c("en",0,coeff_written);
		rd(7'h4c,8'h7e);
		$display("test reset done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
